// >>> adcc_pkg.sv
// Purpose: Shared constants, types and coding function for the converter control block
// Assumes: clk_sys is the converter master clock, one master clock cycle per clk_sys cycle
// Notes: Register offsets are byte addresses on the AHB-Lite slave
`default_nettype none
package adcc_pkg;
   localparam int DATA_W = 20;
   localparam int TMR_W = 12;

   // Filter latency from conversion start to output word: 1624 master clock cycles
   localparam logic [TMR_W-1:0] FILTER_CYCLES = 12'h658;
   // Status flag rises while these counts remain, giving two cycles of warning before the load
   localparam logic [TMR_W-1:0] READY_LEAD = 12'h003;
   localparam logic [TMR_W-1:0] TMR_ONE = 12'h001;
   localparam logic [TMR_W-1:0] TMR_ZERO = 12'h000;

   // Register map
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam logic [7:0] RES_OFF = 8'h08;
   localparam logic [7:0] OFS_OFF = 8'h0c;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam int CTRL_EN_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_CAL_BIT = 1;
   localparam int STAT_VALID_BIT = 2;
   localparam int STAT_CHAN_BIT = 3;
   localparam int STAT_POL_BIT = 4;
   localparam int STAT_CALDONE_BIT = 5;

   localparam logic [DATA_W-1:0] MID_FLIP = 20'h80000;
   localparam logic [DATA_W-1:0] CODE_ZERO = 20'h00000;

   typedef struct packed {
      logic convert_start;
      logic self_cal_request;
      logic polarity_select;
      logic channel_select;
   } adcc_pins_t;

   localparam adcc_pins_t PINS_RST = '{1'b0, 1'b0, 1'b0, 1'b0};

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_MEAS,
      ST_CAL
   } adcc_state_t;

   // Bipolar: offset binary with mid-scale between 7ffff and 80000.
   // Unipolar: negative input clamps to zero, positive half spans full code range.
   function automatic logic [DATA_W-1:0] adcc_code(input logic [DATA_W-1:0] v,
                                                   input logic bip);
      logic [DATA_W-1:0] r;
      r = CODE_ZERO;
      if (bip) begin
         r = v ^ MID_FLIP;
      end else if (!v[DATA_W-1]) begin
         r = {v[DATA_W-2:0], 1'b0};
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// >>> adcc_timer.sv
// Purpose: Down counter timing filter latency and calibration length
// Assumes: load wins over counting; expire marks the last counted cycle
// Notes: Holds at zero when idle
`default_nettype none
module adcc_timer (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ce,
   // Control
   input wire logic load,
   input wire logic [adcc_pkg::TMR_W-1:0] load_val,
   // Status
   output logic [adcc_pkg::TMR_W-1:0] remain,
   output logic expire
);
   import adcc_pkg::*;

   logic [TMR_W-1:0] remain_ff;
   logic [TMR_W-1:0] nxt_remain;

   always_comb begin
      nxt_remain = remain_ff;
      if (load) begin
         nxt_remain = load_val;
      end else if (remain_ff != TMR_ZERO) begin
         nxt_remain = remain_ff - TMR_ONE;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         remain_ff <= TMR_ZERO;
      end else if (ce) begin
         remain_ff <= nxt_remain;
      end
   end

   assign remain = remain_ff;
   assign expire = (remain_ff == TMR_ONE);
endmodule
`default_nettype wire

// >>> adcc_top.sv
// Purpose: Pin-level conversion control of a two-channel converter with an AHB-Lite view
// Assumes: raw inputs are signed samples on clk_sys; control pins are asynchronous
// Notes: AHB-Lite view adds control and status; gain calibration stays at unity
// Function
// - Start edge with calibrate high runs self-calibration
// - Start edge with calibrate low converts
// - Start held high repeats conversions
// - Polarity select high means bipolar coding
// - Channel select zero picks first pair
// - Channel latched only on start edge
// - Undriven channel select reads as zero (no pull-down in this block; the bench drives a released line low)
// - Bipolar mid-scale between 7ffff and 80000
// - Output word after 1624 master cycles
// - Ready flag low when word loaded
//
// The register addresses and the AHB-Lite register port were decided locally.
`default_nettype none
module adcc_top #(
   parameter logic [adcc_pkg::TMR_W-1:0] CAL_CYCLES = 12'hcb0
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic ce,
   // Control pins
   input wire logic convert_start,
   input wire logic self_cal_request,
   input wire logic polarity_select,
   input wire logic channel_select,
   // Modulator samples
   input wire logic [adcc_pkg::DATA_W-1:0] raw_first,
   input wire logic [adcc_pkg::DATA_W-1:0] raw_second,
   // Ready indicator
   output logic result_ready_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   import adcc_pkg::*;

   // Pin synchronisers
   adcc_pins_t pins_raw;
   adcc_pins_t meta_ff;
   adcc_pins_t sync_ff;
   adcc_pins_t prev_ff;
   logic start_edge;

   assign pins_raw = '{convert_start, self_cal_request, polarity_select, channel_select};

   // Reset value zero matches a released channel pin, which the bench drives low; this block has no pull-down
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= PINS_RST;
         sync_ff <= PINS_RST;
         prev_ff <= PINS_RST;
      end else if (ce) begin
         meta_ff <= pins_raw;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign start_edge = sync_ff.convert_start & ~prev_ff.convert_start;

   // Sequencer state
   adcc_state_t state_ff, nxt_state;
   logic chan_ff, nxt_chan;
   logic pol_ff, nxt_pol;
   logic ready_n_ff, nxt_ready_n;
   logic cal_done_ff, nxt_cal_done;
   logic [DATA_W-1:0] result_ff, nxt_result;
   logic [DATA_W-1:0] offset_ff, nxt_offset;
   logic tmr_load;
   logic [TMR_W-1:0] tmr_val;
   logic [TMR_W-1:0] tmr_remain;
   logic tmr_expire;
   logic [DATA_W-1:0] raw_sel;
   logic [DATA_W-1:0] corrected;
   logic enable;
   logic empty_rd;

   adcc_timer u_timer (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .ce(ce),
      .load(tmr_load),
      .load_val(tmr_val),
      .remain(tmr_remain),
      .expire(tmr_expire)
   );

   assign raw_sel = chan_ff ? raw_second : raw_first;
   assign corrected = raw_sel - offset_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_chan = chan_ff;
      nxt_pol = pol_ff;
      nxt_ready_n = ready_n_ff;
      nxt_cal_done = cal_done_ff;
      nxt_result = result_ff;
      nxt_offset = offset_ff;
      tmr_load = 1'b0;
      tmr_val = FILTER_CYCLES;
      // Reading the word empties the port
      if (empty_rd) begin
         nxt_ready_n = 1'b1;
      end
      case (state_ff)
         ST_IDLE: begin
            if (enable && start_edge) begin
               nxt_chan = sync_ff.channel_select;
               tmr_load = 1'b1;
               if (sync_ff.self_cal_request) begin
                  nxt_state = ST_CAL;
                  tmr_val = CAL_CYCLES;
                  nxt_cal_done = 1'b0;
               end else begin
                  nxt_state = ST_MEAS;
                  tmr_val = FILTER_CYCLES;
               end
            end
         end
         ST_MEAS: begin
            if (tmr_remain == READY_LEAD) begin
               nxt_ready_n = 1'b1;
            end
            if (tmr_expire) begin
               nxt_pol = sync_ff.polarity_select;
               nxt_result = adcc_code(corrected, sync_ff.polarity_select);
               // Load wins over a read that empties in the same cycle
               nxt_ready_n = 1'b0;
               if (enable && sync_ff.convert_start && !sync_ff.self_cal_request) begin
                  tmr_load = 1'b1;
                  tmr_val = FILTER_CYCLES;
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_CAL: begin
            // Offset taken with zero input applied; gain scale stays unity
            if (tmr_expire) begin
               nxt_offset = raw_sel;
               nxt_cal_done = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_IDLE;
         chan_ff <= 1'b0;
         pol_ff <= 1'b0;
         ready_n_ff <= 1'b1;
         cal_done_ff <= 1'b0;
         result_ff <= CODE_ZERO;
         offset_ff <= CODE_ZERO;
      end else if (ce) begin
         state_ff <= nxt_state;
         chan_ff <= nxt_chan;
         pol_ff <= nxt_pol;
         ready_n_ff <= nxt_ready_n;
         cal_done_ff <= nxt_cal_done;
         result_ff <= nxt_result;
         offset_ff <= nxt_offset;
      end
   end

   assign result_ready_n = ready_n_ff;

   // Bus slave: zero wait states, reads answered from a flop in the data phase
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [31:0] rdata_ff, nxt_rdata;
   logic wr_pend_ff, nxt_wr_pend;
   logic [7:0] wr_addr_ff, nxt_wr_addr;
   logic addr_ok;
   logic [31:0] status;

   assign enable = ctrl_ff[CTRL_EN_BIT];
   assign addr_ok = hsel && htrans[1] && hready;

   always_comb begin
      status = 32'h0000_0000;
      status[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
      status[STAT_CAL_BIT] = (state_ff == ST_CAL);
      status[STAT_VALID_BIT] = ~ready_n_ff;
      status[STAT_CHAN_BIT] = chan_ff;
      status[STAT_POL_BIT] = pol_ff;
      status[STAT_CALDONE_BIT] = cal_done_ff;
   end

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_rdata = 32'h0000_0000;
      nxt_wr_pend = 1'b0;
      nxt_wr_addr = wr_addr_ff;
      empty_rd = 1'b0;
      if (wr_pend_ff && wr_addr_ff == CTRL_OFF) begin
         nxt_ctrl = {31'h0000_0000, hwdata[CTRL_EN_BIT]};
      end
      if (addr_ok && hwrite) begin
         nxt_wr_pend = 1'b1;
         nxt_wr_addr = haddr[7:0];
      end else if (addr_ok) begin
         if (haddr[7:0] == CTRL_OFF) begin
            nxt_rdata = ctrl_ff;
         end else if (haddr[7:0] == STAT_OFF) begin
            nxt_rdata = status;
         end else if (haddr[7:0] == RES_OFF) begin
            nxt_rdata = {12'h000, result_ff};
            empty_rd = 1'b1;
         end else if (haddr[7:0] == OFS_OFF) begin
            nxt_rdata = {12'h000, offset_ff};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= CTRL_RST;
         rdata_ff <= 32'h0000_0000;
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else if (ce) begin
         ctrl_ff <= nxt_ctrl;
         rdata_ff <= nxt_rdata;
         wr_pend_ff <= nxt_wr_pend;
         wr_addr_ff <= nxt_wr_addr;
      end
   end

   // Response is always OKAY and never stretched; hsize is not checked
   logic hready_ff;
   logic hresp_ff;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hready_ff <= 1'b1;
         hresp_ff <= 1'b0;
      end else if (ce) begin
         hready_ff <= 1'b1;
         hresp_ff <= 1'b0;
      end
   end

   assign hreadyout = hready_ff;
   assign hresp = hresp_ff;
   assign hrdata = rdata_ff;
endmodule
`default_nettype wire

// >>> adcc_properties.sv
// Purpose: Port-level timing checks for the converter control block
// Assumes: ce tied high and hready equal to hreadyout
// Notes: Bound onto adcc_top
`default_nettype none
module adcc_properties
   import adcc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Pins
   input wire logic convert_start,
   input wire logic self_cal_request,
   input wire logic result_ready_n,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire logic rd = hsel && htrans[1] && !hwrite;
   logic rdy_q;
   logic hold;
   logic [3:0] cs_sh;
   logic [TMR_W-1:0] cnt;
   // Spacing between words, and whether start stayed high across the last load
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdy_q <= 1'b1;
         hold <= 1'b0;
         cs_sh <= 4'h0;
         cnt <= 12'h000;
      end else begin
         rdy_q <= result_ready_n;
         cs_sh <= {cs_sh[2:0], convert_start};
         if (rdy_q && !result_ready_n) begin
            cnt <= 12'h001;
            hold <= &cs_sh && convert_start && !self_cal_request;
         end else if (cnt != 12'hfff) begin
            cnt <= cnt + 12'h001;
         end
      end
   end
   property p_hready; hreadyout; endproperty
   a_hready: assert property (p_hready) else $error("wait state");
   property p_hresp; !hresp; endproperty
   a_hresp: assert property (p_hresp) else $error("error response");
   property p_rd_idle; !$past(rd) |-> hrdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
   property p_rd_unmap; $past(rd && haddr[7:4] != 4'h0) |-> hrdata == 32'h0; endproperty
   a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
   property p_warn; $fell(result_ready_n) |-> $past(result_ready_n, 2); endproperty
   a_warn: assert property (p_warn) else $error("no warning before load");
   property p_empty; rd && haddr[7:0] == RES_OFF && !result_ready_n |=> result_ready_n;
   endproperty
   a_empty: assert property (p_empty) else $error("read left port full");
   property p_stat;
      $past(rd && haddr[7:0] == STAT_OFF) |-> hrdata[STAT_VALID_BIT] == !$past(result_ready_n);
   endproperty
   a_stat: assert property (p_stat) else $error("status valid wrong");
   property p_period; $fell(result_ready_n) && hold |-> cnt == FILTER_CYCLES; endproperty
   a_period: assert property (p_period) else $error("continuous spacing");
endmodule
bind adcc_top adcc_properties i_props (.clk_sys(clk_sys), .rst_b(rst_b),
   .convert_start(convert_start), .self_cal_request(self_cal_request),
   .result_ready_n(result_ready_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

// >>> adcc_host_model.sv
// Purpose: Host model driving the converter control pins
// Assumes: pins change just after a rising edge
// Notes: Channel line may be released; the bench supplies its pull-down
`default_nettype none
module adcc_host_model (
   // Clock
   input wire logic clk_sys,
   // Pins
   output var adcc_pkg::adcc_pins_t pins,
   output var logic ch_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   import adcc_pkg::*;
   initial begin
      pins = PINS_RST;
      ch_oe = 1'b1;
   end
   // Calibrate and channel move with start; a repeat call rewrites calibrate, polarity and channel while start stays high
   task automatic go(input logic cal, ch, oe, pol);
      @(posedge clk_sys);
      pins <= '{1'b1, cal, pol, ch};
      ch_oe <= oe;
   endtask
   // Callers hold start for several cycles so the sampled edge is never missed
   task automatic stop();
      @(posedge clk_sys);
      pins <= '{1'b0, 1'b0, pins.polarity_select, pins.channel_select};
   endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: zero-wait bus slave, short calibration
// Notes: A monitor reads each word and checks it against the oldest note
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
   $display("Error %0t: got %h want %h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import adcc_pkg::*;
   typedef struct {int t; logic [DATA_W-1:0] code;} adcc_note_t;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [DATA_W-1:0] raw1 = 20'h0;
   logic [DATA_W-1:0] raw2 = 20'h0;
   logic [31:0] hrdata, rdat;
   logic hrdy, hresp, rdy_n, ch_oe;
   adcc_pins_t pins;
   adcc_note_t q[$];
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int seed = 32'h2198410b;
   adcc_top #(.CAL_CYCLES(12'h008)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1),
      .convert_start(pins.convert_start), .self_cal_request(pins.self_cal_request),
      .polarity_select(pins.polarity_select), .raw_first(raw1), .raw_second(raw2),
      .channel_select(ch_oe ? pins.channel_select : 1'b0), .result_ready_n(rdy_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata));
   adcc_host_model i_host (.clk_sys(clk_sys), .pins(pins), .ch_oe(ch_oe));
   initial forever #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc++;
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic fail(input string m);
      err_count++;
      $display("Error %0t: %s", $time, m);
      report_and_stop();
   endtask
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      n = 0;
      do @(posedge clk_sys); while (hrdy !== 1'b1 && ++n < 64);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hrdy !== 1'b1 && ++n < 64);
      rdat = hrdata;
      if (n >= 64) fail("bus hang");
   endtask
   function automatic logic [DATA_W-1:0] want(input logic [DATA_W-1:0] v, input logic b);
      if (b) return v ^ 20'h80000;
      return v[DATA_W-1] ? 20'h0 : {v[DATA_W-2:0], 1'b0};
   endfunction
   task automatic wait_q(input int n);
      for (int k = 0; q.size() > n; k++) begin
         if (k > 4000) fail("word missing");
         @(posedge clk_sys);
      end
   endtask
   // Start a conversion; a held start expects a second word one period later
   // A released channel line carries a 1 so that only the pull-down can pick the first pair
   task automatic meas(input logic ch, oe, b, input logic [DATA_W-1:0] v, ofs, input int hold);
      if (ch) raw2 <= v;
      else raw1 <= v;
      i_host.go(1'b0, ch | ~oe, oe, b);
      #1;
      q.push_back(adcc_note_t'{cyc + 3 + FILTER_CYCLES, want(v - ofs, b)});
      if (hold > 0) begin
         q.push_back(adcc_note_t'{cyc + 3 + 2 * FILTER_CYCLES, want(v - ofs, b)});
      end
      repeat (4) @(posedge clk_sys);
      if (hold == 0) i_host.stop();
   endtask
   initial begin
      logic prev;
      prev = 1'b1;
      forever begin
         @(posedge clk_sys);
         #1;
         if (prev === 1'b1 && rdy_n === 1'b0) begin
            if (q.size() == 0) fail("unexpected word");
            `CHK(cyc, q[0].t)
            ahb(RES_OFF, 1'b0, 32'h0);
            `CHK(rdat, {12'h0, q[0].code})
            void'(q.pop_front());
         end
         prev = rdy_n;
      end
   end
   initial begin
      logic [DATA_W-1:0] r;
      logic [31:0] x;
      logic [7:0] offs [5];
      logic [31:0] rv [5];
      offs = '{CTRL_OFF, STAT_OFF, RES_OFF, OFS_OFF, 8'h10};
      rv = '{CTRL_RST, 32'h0, 32'h0, 32'h0, 32'h0};
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      // Writes to read-only and unmapped places must leave everything at reset
      ahb(STAT_OFF, 1'b1, 32'hffff_ffff);
      ahb(8'h10, 1'b1, 32'hffff_ffff);
      for (int i = 0; i < 5; i++) begin
         ahb(offs[i], 1'b0, 32'h0);
         `CHK(rdat, rv[i])
      end
      $display("end registers");
      x = $random(seed);
      r = x[DATA_W-1:0];
      raw1 <= r;
      i_host.go(1'b1, 1'b0, 1'b1, 1'b0);
      repeat (4) @(posedge clk_sys);
      i_host.stop();
      for (int k = 0; k < 64 && rdat[STAT_CALDONE_BIT] !== 1'b1; k++) ahb(STAT_OFF, 1'b0, 32'h0);
      if (rdat[STAT_CALDONE_BIT] !== 1'b1) fail("calibration hang");
      ahb(OFS_OFF, 1'b0, 32'h0);
      `CHK(rdat, {12'h0, r})
      $display("end calibration");
      for (int i = 0; i < 4; i++) begin
         x = (i == 3) ? $random(seed) : 1 - i;
         meas(1'b0, i[1], i[0], r + x[DATA_W-1:0], r, 0);
         wait_q(0);
      end
      $display("end single");
      x = $random(seed);
      meas(1'b1, 1'b1, 1'b1, x[DATA_W-1:0], r, 1);
      i_host.go(1'b0, 1'b0, 1'b1, 1'b1);
      wait_q(1);
      i_host.stop();
      wait_q(0);
      ahb(STAT_OFF, 1'b0, 32'h0);
      `CHK(rdat[STAT_CHAN_BIT], 1'b1)
      `CHK(rdat[STAT_POL_BIT], 1'b1)
      ahb(CTRL_OFF, 1'b1, 32'h0);
      i_host.go(1'b0, 1'b0, 1'b1, 1'b1);
      repeat (4) @(posedge clk_sys);
      i_host.stop();
      repeat (1700) @(posedge clk_sys);
      // Start was refused while disabled, so the sequencer must still be idle
      ahb(STAT_OFF, 1'b0, 32'h0);
      `CHK(rdat[STAT_BUSY_BIT], 1'b0)
      ahb(CTRL_OFF, 1'b1, CTRL_RST);
      $display("end continuous");
      report_and_stop();
   end
endmodule
`default_nettype wire
